// ===== verilog/slcc_pkg.sv
// shared constants for the serial link configuration checker
package slcc_pkg;
  // register addresses (16-bit)
  localparam logic [15:0] ADDR_BAND = 16'h056E;
  localparam logic [15:0] ADDR_LANES = 16'h0580;
  localparam logic [15:0] ADDR_CONV = 16'h0581;
  localparam logic [15:0] ADDR_OCTETS = 16'h0582;
  localparam logic [15:0] ADDR_SAMPLES = 16'h0583;
  localparam logic [15:0] ADDR_RES = 16'h0584;
  localparam logic [15:0] ADDR_CTRL = 16'h0585;
  localparam logic [15:0] ADDR_DCM = 16'h0586;
  localparam logic [15:0] ADDR_CLK = 16'h0587;
  localparam int NUM_FIELDS = 8;
  // reset values
  localparam logic [7:0] RST_BAND = 8'h00;
  localparam logic [4:0] RST_LANES = 5'h01;
  localparam logic [4:0] RST_CONV = 5'h02;
  localparam logic [4:0] RST_OCTETS = 5'h04;
  localparam logic [4:0] RST_SAMPLES = 5'h01;
  localparam logic [4:0] RST_RES = 5'h10;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [5:0] RST_DCM = 6'h01;
  localparam logic [11:0] RST_CLK = 12'h3E8;
  // band codes
  localparam logic [7:0] BAND_TOP = 8'h30;
  localparam logic [7:0] BAND_HIGH = 8'h00;
  localparam logic [7:0] BAND_MID = 8'h10;
  localparam logic [7:0] BAND_LOW = 8'h50;
  // lane rate limits, in Mbps (halves kept doubled to stay integral)
  localparam logic [31:0] SLR_MIN_X2 = 32'h0000_0D2F; // 3375 = 2*1687.5
  localparam logic [31:0] SLR_MAX = 32'h0000_3C8C; // 15500
  localparam logic [31:0] SLR_B_TOP = 32'h0000_34BC; // 13500
  localparam logic [31:0] SLR_B_MID = 32'h0000_1A5E; // 6750
  localparam logic [31:0] SLR_B_LOW = 32'h0000_0D2F; // 3375
  localparam logic [31:0] WORD_BITS = 32'h0000_0010; // 16-bit sample words
  localparam logic [31:0] CODE_NUM = 32'h0000_000A; // 10b/8b line code
  localparam logic [31:0] CODE_DEN = 32'h0000_0008;
  localparam logic [31:0] CLK_DIV_LIMIT = 32'h0000_0028; // 40
  localparam logic [31:0] LCM_LIMIT = 32'h0000_0040; // 64
  localparam logic [4:0] MIN_RES = 5'h08;
  localparam logic [4:0] MAX_F = 5'h10;
  // error flag positions
  localparam int ERR_RATE = 0;
  localparam int ERR_CLKDIV = 1;
  localparam int ERR_LCM = 2;
  localparam int ERR_BAND = 3;
  localparam int ERR_PAIR = 4;
  localparam int ERR_WORD = 5;
  localparam int ERR_DCM = 6;
  localparam int ERR_W = 7;
  localparam int SETTLE_CYCLES = 3;
endpackage : slcc_pkg

// ===== verilog/slcc_link_if.sv
// configuration link between host and converter ends
`timescale 1ns/10ps
interface slcc_link_if;
  logic wr;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic link_pd;
  logic [6:0] err;
  logic [7:0] band_hint;
  logic hd;
  logic chk_valid;
  modport dev_mp (input wr, addr, wdata, link_pd,
                  output err, band_hint, hd, chk_valid);
  modport host_mp (output wr, addr, wdata, link_pd,
                   input err, band_hint, hd, chk_valid);
endinterface : slcc_link_if

// ===== verilog/slcc_dev.sv
// converter end: link configuration registers and rate checker
//
// Behaviour
// - lane rate 1.6875 to 15.5 Gbps
// - lane rate over 40 within sample clock
// - divider lcm term at most 64
// - band 0x30 above 13500, 0x00 from 6750
// - band 0x10 from 3375, 0x50 from 1687.5
// - only listed parameter and decimation combinations
// - 16-bit words, resolution 8 to 16
// - zero to three control bits per word
// - S samples per converter: 1, 2 or 4
// - F octets per lane frame, 1 to 16
// - high density set when F is one
// - lanes 1,2,4,8; converters 2,4,8
// - M8 L1 F16 gives 160 times output rate
// - M8 L8 F2 gives 20 times output rate
// - rate = M*N'*10/8*output_sample_rate/L, output_sample_rate = clk/dcm
// - host powers link down while configuring
`timescale 1ns/10ps
module slcc_dev (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  slcc_link_if.dev_mp link,
  output logic [4:0] lanes_out,
  output logic [4:0] converters_out,
  output logic [4:0] octets_out,
  output logic [4:0] samples_out,
  output logic [4:0] resolution_out,
  output logic [1:0] ctrl_bits_out,
  output logic [7:0] lane_rate_band_out,
  output logic cfg_ok_out
);
  logic [4:0] lanes_q;
  logic [4:0] conv_q;
  logic [4:0] octets_q;
  logic [4:0] samples_q;
  logic [4:0] res_q;
  logic [1:0] ctrl_q;
  logic [5:0] dcm_q;
  logic [11:0] clk_q;
  logic [7:0] lane_rate_band_select_q;
  logic [31:0] lhs_d;
  logic [31:0] rhs_d;
  logic [31:0] lcm_d;
  logic [6:0] err_d;
  logic [7:0] band_d;
  logic [6:0] err_q;
  logic [7:0] band_hint_q;
  logic hd_q;
  logic chk_q;
  logic [1:0] settle_q;

  function automatic logic pow2_1to8(input logic [4:0] v);
    pow2_1to8 = (v == 5'h01) || (v == 5'h02) || (v == 5'h04)
      || (v == 5'h08);
  endfunction : pow2_1to8

  function automatic logic dcm_listed(input logic [5:0] d);
    case (d)
      6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h0A, 6'h0C,
      6'h0F, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h28, 6'h30: dcm_listed = 1'b1;
      default: dcm_listed = 1'b0;
    endcase
  endfunction : dcm_listed

  // register writes only land while the link is powered down
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      lanes_q <= slcc_pkg::RST_LANES;
      conv_q <= slcc_pkg::RST_CONV;
      octets_q <= slcc_pkg::RST_OCTETS;
      samples_q <= slcc_pkg::RST_SAMPLES;
      res_q <= slcc_pkg::RST_RES;
      ctrl_q <= slcc_pkg::RST_CTRL;
      dcm_q <= slcc_pkg::RST_DCM;
      clk_q <= slcc_pkg::RST_CLK;
      lane_rate_band_select_q <= slcc_pkg::RST_BAND;
    end
    else if (link.wr && link.link_pd)
    begin
      if (link.addr == slcc_pkg::ADDR_LANES)
        lanes_q <= link.wdata[4:0];
      else if (link.addr == slcc_pkg::ADDR_CONV)
        conv_q <= link.wdata[4:0];
      else if (link.addr == slcc_pkg::ADDR_OCTETS)
        octets_q <= link.wdata[4:0];
      else if (link.addr == slcc_pkg::ADDR_SAMPLES)
        samples_q <= link.wdata[4:0];
      else if (link.addr == slcc_pkg::ADDR_RES)
        res_q <= link.wdata[4:0];
      else if (link.addr == slcc_pkg::ADDR_CTRL)
        ctrl_q <= link.wdata[1:0];
      else if (link.addr == slcc_pkg::ADDR_DCM)
        dcm_q <= link.wdata[5:0];
      else if (link.addr == slcc_pkg::ADDR_CLK)
        clk_q <= link.wdata[11:0];
      else if (link.addr == slcc_pkg::ADDR_BAND)
        lane_rate_band_select_q <= link.wdata[7:0];
    end
  end

  // rate kept as a ratio: slr * dcm * lanes == lhs, no divider needed
  always_comb
  begin
    lhs_d = 32'(slcc_pkg::WORD_BITS * 32'(conv_q) * slcc_pkg::CODE_NUM
      * 32'(clk_q) / slcc_pkg::CODE_DEN);
    rhs_d = 32'(dcm_q) * 32'(lanes_q);
    // lcm(dcm*L/M, dcm): a multiple of dcm when L >= M, else dcm
    if (lanes_q >= conv_q)
      lcm_d = 32'(32'(dcm_q) * 32'(lanes_q) / 32'(conv_q));
    else
      lcm_d = 32'(dcm_q);
    err_d = '0;
    if (32'(lhs_d * 32'h0000_0002) < 32'(slcc_pkg::SLR_MIN_X2 * rhs_d)
        || lhs_d > 32'(slcc_pkg::SLR_MAX * rhs_d))
      err_d[slcc_pkg::ERR_RATE] = 1'b1;
    if (lhs_d > 32'(slcc_pkg::CLK_DIV_LIMIT * 32'(clk_q) * rhs_d))
      err_d[slcc_pkg::ERR_CLKDIV] = 1'b1;
    if (lcm_d > slcc_pkg::LCM_LIMIT
        || (lanes_q < conv_q
            && (32'(dcm_q) * 32'(lanes_q)) % 32'(conv_q) != 32'h0))
      err_d[slcc_pkg::ERR_LCM] = 1'b1;
    if (lhs_d > 32'(slcc_pkg::SLR_B_TOP * rhs_d))
      band_d = slcc_pkg::BAND_TOP;
    else if (lhs_d >= 32'(slcc_pkg::SLR_B_MID * rhs_d))
      band_d = slcc_pkg::BAND_HIGH;
    else if (lhs_d >= 32'(slcc_pkg::SLR_B_LOW * rhs_d))
      band_d = slcc_pkg::BAND_MID;
    else
      band_d = slcc_pkg::BAND_LOW;
    if (band_d != lane_rate_band_select_q)
      err_d[slcc_pkg::ERR_BAND] = 1'b1;
    // frame geometry: F * L octets carry M * S two-octet words
    if (!pow2_1to8(lanes_q) || !pow2_1to8(conv_q)
        || conv_q == 5'h01
        || !(samples_q == 5'h01 || samples_q == 5'h02
             || samples_q == 5'h04)
        || octets_q == 5'h00 || octets_q > slcc_pkg::MAX_F
        || 10'(octets_q) * 10'(lanes_q)
           != 10'(conv_q) * 10'(samples_q) * 10'h002)
      err_d[slcc_pkg::ERR_PAIR] = 1'b1;
    if (res_q < slcc_pkg::MIN_RES
        || 6'(res_q) + 6'(ctrl_q) > 6'(slcc_pkg::WORD_BITS))
      err_d[slcc_pkg::ERR_WORD] = 1'b1;
    if (!dcm_listed(dcm_q) || clk_q == 12'h000)
      err_d[slcc_pkg::ERR_DCM] = 1'b1;
  end

  // verdict registered; valid only after the settle window since a write
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      err_q <= '0;
      band_hint_q <= slcc_pkg::RST_BAND;
      hd_q <= 1'b0;
    end
    else
    begin
      err_q <= err_d;
      band_hint_q <= band_d;
      hd_q <= (octets_q == 5'h01);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      settle_q <= 2'h0;
    else if (link.wr)
      settle_q <= 2'(slcc_pkg::SETTLE_CYCLES - 1);
    else if (settle_q != 2'h0)
      settle_q <= settle_q - 2'h1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      chk_q <= 1'b0;
    else
      chk_q <= !link.wr && settle_q == 2'h0;
  end

  // user-side copies, frozen while the link is down
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      lanes_out <= slcc_pkg::RST_LANES;
      converters_out <= slcc_pkg::RST_CONV;
      octets_out <= slcc_pkg::RST_OCTETS;
      samples_out <= slcc_pkg::RST_SAMPLES;
      resolution_out <= slcc_pkg::RST_RES;
      ctrl_bits_out <= slcc_pkg::RST_CTRL;
      lane_rate_band_out <= slcc_pkg::RST_BAND;
      cfg_ok_out <= 1'b0;
    end
    else
    begin
      if (!link.link_pd)
      begin
        lanes_out <= lanes_q;
        converters_out <= conv_q;
        octets_out <= octets_q;
        samples_out <= samples_q;
        resolution_out <= res_q;
        ctrl_bits_out <= ctrl_q;
        lane_rate_band_out <= lane_rate_band_select_q;
      end
      cfg_ok_out <= chk_q && err_q == '0 && !link.link_pd;
    end
  end

  assign link.err = err_q;
  assign link.band_hint = band_hint_q;
  assign link.hd = hd_q;
  assign link.chk_valid = chk_q;
endmodule : slcc_dev

// ===== verilog/slcc_host.sv
// host end: writes a configuration, sets the band, powers the link up
`timescale 1ns/10ps
module slcc_host (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  slcc_link_if.host_mp link,
  input wire logic start_in,
  input wire logic [4:0] lanes_in,
  input wire logic [4:0] converters_in,
  input wire logic [4:0] octets_in,
  input wire logic [4:0] samples_in,
  input wire logic [4:0] resolution_in,
  input wire logic [1:0] ctrl_bits_in,
  input wire logic [5:0] dcm_in,
  input wire logic [11:0] clk_mhz_in,
  output logic busy_out,
  output logic done_out,
  output logic fault_out,
  output logic [6:0] err_out
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_WRITE = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_BAND = 6'b001000,
    ST_CHECK = 6'b010000,
    ST_UP = 6'b100000
  } slcc_state_t;

  slcc_state_t state_q;
  logic [2:0] idx_q;
  logic band_done_q;
  logic wr_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic pd_q;
  logic [15:0] addr_d;
  logic [15:0] wdata_d;

  always_comb
  begin
    case (idx_q)
      3'h0: addr_d = slcc_pkg::ADDR_LANES;
      3'h1: addr_d = slcc_pkg::ADDR_CONV;
      3'h2: addr_d = slcc_pkg::ADDR_OCTETS;
      3'h3: addr_d = slcc_pkg::ADDR_SAMPLES;
      3'h4: addr_d = slcc_pkg::ADDR_RES;
      3'h5: addr_d = slcc_pkg::ADDR_CTRL;
      3'h6: addr_d = slcc_pkg::ADDR_DCM;
      default: addr_d = slcc_pkg::ADDR_CLK;
    endcase
    case (idx_q)
      3'h0: wdata_d = 16'(lanes_in);
      3'h1: wdata_d = 16'(converters_in);
      3'h2: wdata_d = 16'(octets_in);
      3'h3: wdata_d = 16'(samples_in);
      3'h4: wdata_d = 16'(resolution_in);
      3'h5: wdata_d = 16'(ctrl_bits_in);
      3'h6: wdata_d = 16'(dcm_in);
      default: wdata_d = 16'(clk_mhz_in);
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= ST_IDLE;
      idx_q <= 3'h0;
      band_done_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      pd_q <= 1'b1;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      fault_out <= 1'b0;
      err_out <= '0;
    end
    else
    begin
      wr_q <= 1'b0;
      done_out <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start_in)
          begin
            pd_q <= 1'b1;
            idx_q <= 3'h0;
            band_done_q <= 1'b0;
            busy_out <= 1'b1;
            fault_out <= 1'b0;
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          wr_q <= 1'b1;
          addr_q <= addr_d;
          wdata_q <= wdata_d;
          idx_q <= idx_q + 3'h1;
          if (idx_q == 3'(slcc_pkg::NUM_FIELDS - 1))
            state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (link.chk_valid && !wr_q)
            state_q <= band_done_q ? ST_CHECK : ST_BAND;
        end
        ST_BAND:
        begin
          // band follows the rate the converter computed
          wr_q <= 1'b1;
          addr_q <= slcc_pkg::ADDR_BAND;
          wdata_q <= 16'(link.band_hint);
          band_done_q <= 1'b1;
          state_q <= ST_WAIT;
        end
        ST_CHECK:
        begin
          err_out <= link.err;
          // any fault flag (rate, divider, lcm, band, pair, word or decimation listing) keeps the link down
          if (link.err != '0)
          begin
            fault_out <= 1'b1;
            busy_out <= 1'b0;
            state_q <= ST_IDLE;
          end
          else
          begin
            pd_q <= 1'b0;
            state_q <= ST_UP;
          end
        end
        ST_UP:
        begin
          done_out <= 1'b1;
          busy_out <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign link.wr = wr_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.link_pd = pd_q;
endmodule : slcc_host

// ===== tb/slcc_monitor.sv
// concurrent checks on the configuration link between the two ends
`timescale 1ns/10ps
module slcc_monitor (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic link_pd,
  input wire logic [6:0] err,
  input wire logic [7:0] band_hint,
  input wire logic hd,
  input wire logic chk_valid
);
  logic [4:0] l_q, m_q, f_q, n_q;
  logic [1:0] cs_q;
  logic [5:0] d_q;
  logic [11:0] c_q;
  logic [7:0] b_q, eb;
  logic [31:0] rx, den, lv;
  logic ok, rng;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // shadow of the device registers, fed only by writes that land
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      l_q <= slcc_pkg::RST_LANES;
      m_q <= slcc_pkg::RST_CONV;
      f_q <= slcc_pkg::RST_OCTETS;
      n_q <= slcc_pkg::RST_RES;
      cs_q <= slcc_pkg::RST_CTRL;
      d_q <= slcc_pkg::RST_DCM;
      c_q <= slcc_pkg::RST_CLK;
      b_q <= slcc_pkg::RST_BAND;
    end
    else if (wr && link_pd)
    begin
      case (addr)
        slcc_pkg::ADDR_LANES: l_q <= wdata[4:0];
        slcc_pkg::ADDR_CONV: m_q <= wdata[4:0];
        slcc_pkg::ADDR_OCTETS: f_q <= wdata[4:0];
        slcc_pkg::ADDR_RES: n_q <= wdata[4:0];
        slcc_pkg::ADDR_CTRL: cs_q <= wdata[1:0];
        slcc_pkg::ADDR_DCM: d_q <= wdata[5:0];
        slcc_pkg::ADDR_CLK: c_q <= wdata[11:0];
        slcc_pkg::ADDR_BAND: b_q <= wdata[7:0];
        default: ;
      endcase
    end
  end
  // rate kept as rx/den so the half-Mbps boundary stays exact
  always_comb
  begin
    den = 32'(d_q) * 32'(l_q);
    rx = 32'(m_q) * 32'(c_q) * 32'h14;
    ok = (den != 32'h0) && (m_q != 5'h00);
    rng = (rx * 32'h2 >= slcc_pkg::SLR_MIN_X2 * den) &&
          (rx <= slcc_pkg::SLR_MAX * den);
    lv = (ok && den / 32'(m_q) > 32'(d_q)) ? den / 32'(m_q) : 32'(d_q);
    if (rx > slcc_pkg::SLR_B_TOP * den) eb = slcc_pkg::BAND_TOP;
    else if (rx >= slcc_pkg::SLR_B_MID * den) eb = slcc_pkg::BAND_HIGH;
    else if (rx >= slcc_pkg::SLR_B_LOW * den) eb = slcc_pkg::BAND_MID;
    else eb = slcc_pkg::BAND_LOW;
  end
  property p_hd;
    chk_valid |-> hd == (f_q == 5'h01);
  endproperty
  a_hd: assert property (p_hd) else $error("hd wrong");
  property p_drop;
    wr && link_pd |=> !chk_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("no settle drop");
  property p_settle;
    // settle counter plus the chk flop: valid is seen on the fourth edge
    (wr && link_pd) ##1 !wr [*3] |=> chk_valid;
  endproperty
  a_settle: assert property (p_settle) else $error("late settle");
  property p_stable;
    chk_valid && $past(chk_valid) |-> $stable(err) && $stable(band_hint);
  endproperty
  a_stable: assert property (p_stable) else $error("flags moved");
  property p_rate;
    chk_valid && ok |-> err[slcc_pkg::ERR_RATE] == !rng;
  endproperty
  a_rate: assert property (p_rate) else $error("rate flag wrong");
  property p_div;
    chk_valid && ok |->
      err[slcc_pkg::ERR_CLKDIV] == (rx > 32'(c_q) * 32'h28 * den);
  endproperty
  a_div: assert property (p_div) else $error("divider flag wrong");
  property p_lcm;
    chk_valid && ok && (den % 32'(m_q) == 32'h0) |->
      err[slcc_pkg::ERR_LCM] == (lv > 32'h40);
  endproperty
  a_lcm: assert property (p_lcm) else $error("lcm flag wrong");
  property p_band;
    chk_valid && ok && rng |->
      band_hint == eb && err[slcc_pkg::ERR_BAND] == (b_q != eb);
  endproperty
  a_band: assert property (p_band) else $error("band wrong");
  property p_word;
    chk_valid && cs_q == 2'h0 |->
      err[slcc_pkg::ERR_WORD] == (n_q < 5'h08 || n_q > 5'h10);
  endproperty
  a_word: assert property (p_word) else $error("word flag wrong");
  c_hd: cover property (chk_valid && hd);
  c_low: cover property (chk_valid && band_hint == slcc_pkg::BAND_LOW);
  c_err: cover property (chk_valid && err[slcc_pkg::ERR_RATE]);
endmodule : slcc_monitor

// ===== tb/slcc_tb_top.sv
// self-checking bench: host end drives the converter end over the link
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp=%0h got=%0h", nm, e, g); end end
module slcc_tb_top;
  typedef struct packed {
    logic [4:0] l, m, f, s, n;
    logic [1:0] cs;
    logic [7:0] band;
    logic ok;
    logic [2:0] eb;
  } slcc_exp_t;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic start_in = 1'b0;
  logic [4:0] lanes_in = 5'h01, conv_in = 5'h02, oct_in = 5'h04;
  logic [4:0] smp_in = 5'h01, res_in = 5'h10;
  logic [1:0] cs_in = 2'h0;
  logic [5:0] dcm_in = 6'h01;
  logic [11:0] clk_in = 12'h3E8;
  logic busy_out, done_out, fault_out, cfg_ok_out, flt_q = 1'b0;
  logic [6:0] err_out;
  logic [4:0] lanes_out, conv_out, oct_out, smp_out, res_out;
  logic [1:0] cs_out;
  logic [7:0] band_out;
  int err_count = 0;
  int comparisons = 0;
  int seed = 56602;
  slcc_exp_t exp_q[$];
  always #2.5 mclk_in = ~mclk_in;
  slcc_link_if u_slcc_link_if ();
  slcc_dev u_slcc_dev (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .link(u_slcc_link_if), .lanes_out(lanes_out), .converters_out(conv_out),
    .octets_out(oct_out), .samples_out(smp_out), .resolution_out(res_out),
    .ctrl_bits_out(cs_out), .lane_rate_band_out(band_out),
    .cfg_ok_out(cfg_ok_out));
  slcc_host u_slcc_host (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .link(u_slcc_link_if), .start_in(start_in), .lanes_in(lanes_in),
    .converters_in(conv_in), .octets_in(oct_in), .samples_in(smp_in),
    .resolution_in(res_in), .ctrl_bits_in(cs_in), .dcm_in(dcm_in),
    .clk_mhz_in(clk_in), .busy_out(busy_out), .done_out(done_out),
    .fault_out(fault_out), .err_out(err_out));
  slcc_monitor u_slcc_monitor (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .wr(u_slcc_link_if.wr), .addr(u_slcc_link_if.addr),
    .wdata(u_slcc_link_if.wdata), .link_pd(u_slcc_link_if.link_pd),
    .err(u_slcc_link_if.err), .band_hint(u_slcc_link_if.band_hint),
    .hd(u_slcc_link_if.hd), .chk_valid(u_slcc_link_if.chk_valid));
  task automatic summarize;
    // a note still queued is a result that never showed up
    if (exp_q.size() != 0) err_count++;
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic run(input logic [4:0] l, m, f, s, input logic [5:0] d,
    input logic [11:0] c, input logic [7:0] band, input logic ok,
    input logic [2:0] eb);
    slcc_exp_t x;
    x = '{l, m, f, s, 5'h08 + 5'($unsigned($random(seed)) % 6),
      2'($unsigned($random(seed))), band, ok, eb};
    // resolution below the word floor must be refused
    if (!ok && eb == 3'h5) x.n = 5'h07;
    @(posedge mclk_in);
    lanes_in <= l;
    conv_in <= m;
    oct_in <= f;
    smp_in <= s;
    res_in <= x.n;
    cs_in <= x.cs;
    dcm_in <= d;
    clk_in <= c;
    start_in <= 1'b1;
    exp_q.push_back(x);
    @(posedge mclk_in);
    start_in <= 1'b0;
    repeat (200)
    begin
      @(posedge mclk_in);
      if (busy_out === 1'b0) break;
    end
    // host still busy after the limit: a hang, not a silent skip
    if (busy_out !== 1'b0) err_count++;
    repeat (6) @(posedge mclk_in);
  endtask : run
  task automatic check;
    slcc_exp_t x;
    x = exp_q.pop_front();
    // user copies and cfg_ok lag the power-up by a flop or two
    repeat (2) @(posedge mclk_in);
    if (x.ok)
    begin
      `CHK("fault", 1'b0, fault_out)
      `CHK("err", 7'h00, err_out)
      `CHK("band", x.band, band_out)
      `CHK("hint", x.band, u_slcc_link_if.band_hint)
      `CHK("hd", x.f == 5'h01, u_slcc_link_if.hd)
      `CHK("lanes", x.l, lanes_out)
      `CHK("conv", x.m, conv_out)
      `CHK("octets", x.f, oct_out)
      `CHK("samples", x.s, smp_out)
      `CHK("res", x.n, res_out)
      `CHK("ctrl", x.cs, cs_out)
      `CHK("cfg_ok", 1'b1, cfg_ok_out)
    end
    else
    begin
      `CHK("fault", 1'b1, fault_out)
      `CHK("errbit", 1'b1, err_out[x.eb])
      `CHK("cfg_ok", 1'b0, cfg_ok_out)
    end
  endtask : check
  always @(posedge mclk_in)
  begin
    flt_q <= fault_out;
    if (done_out === 1'b1 || (fault_out === 1'b1 && flt_q !== 1'b1))
      check();
  end
  initial
  begin
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    run(5'h08, 5'h08, 5'h02, 5'h01, 6'h02, 12'h3E8, 8'h00, 1'b1, 3'h0);
    run(5'h01, 5'h08, 5'h10, 5'h01, 6'h10, 12'h3E8, 8'h00, 1'b1, 3'h0);
    run(5'h04, 5'h02, 5'h01, 5'h01, 6'h04, 12'h7D0, 8'h10, 1'b1, 3'h0);
    run(5'h08, 5'h02, 5'h01, 5'h02, 6'h02, 12'h2A3, 8'h50, 1'b1, 3'h0);
    run(5'h01, 5'h02, 5'h04, 5'h01, 6'h02, 12'h2EE, 8'h30, 1'b1, 3'h0);
    run(5'h02, 5'h04, 5'h08, 5'h02, 6'h08, 12'h7D0, 8'h00, 1'b1, 3'h0);
    run(5'h08, 5'h02, 5'h02, 5'h04, 6'h01, 12'h640, 8'h00, 1'b1, 3'h0);
    run(5'h08, 5'h02, 5'h01, 5'h02, 6'h02, 12'h2A2, 8'h00, 1'b0, 3'h0);
    run(5'h01, 5'h02, 5'h04, 5'h01, 6'h01, 12'h3E8, 8'h00, 1'b0, 3'h0);
    run(5'h01, 5'h08, 5'h10, 5'h01, 6'h01, 12'h060, 8'h00, 1'b0, 3'h1);
    run(5'h08, 5'h08, 5'h02, 5'h01, 6'h02, 12'h3E8, 8'h00, 1'b0, 3'h5);
    run(5'h04, 5'h02, 5'h01, 5'h01, 6'h04, 12'h7D0, 8'h10, 1'b1, 3'h0);
    summarize();
  end
  // a dozen runs of about 30 cycles each; far more means a hang
  initial
  begin
    repeat (6000) @(posedge mclk_in);
    err_count++;
    summarize();
  end
endmodule : slcc_tb_top
